// ===== dtc_pkg.sv
// Package for the dual 8-bit timer control block
package dtc_pkg;
  // Register byte offsets (word aligned on the bus, except B control at 8'h19)
  localparam logic [7:0] DTC_A_CTRL_OFF = 8'h18;
  localparam logic [7:0] DTC_B_CTRL_OFF = 8'h19;
  localparam logic [7:0] DTC_A_PERIOD_OFF = 8'h20;
  localparam logic [7:0] DTC_A_WIDTH_OFF = 8'h24;
  localparam logic [7:0] DTC_B_PERIOD_OFF = 8'h28;
  localparam logic [7:0] DTC_B_WIDTH_OFF = 8'h2C;
  localparam logic [7:0] DTC_STATUS_OFF = 8'h30;
  localparam logic [7:0] DTC_OPT_OFF = 8'h34;
  // Control register fields
  localparam int DTC_FF_BIT = 7;
  localparam int DTC_CK_LSB = 4;
  localparam int DTC_RUN_BIT = 3;
  localparam int DTC_MODE_LSB = 0;
  localparam logic [7:0] DTC_CTRL_RST = 8'h00;
  localparam logic [7:0] DTC_REG_RST = 8'h00;
  // Mode codes
  localparam logic [2:0] DTC_M_TIMER8 = 3'h0;
  localparam logic [2:0] DTC_M_PDO8 = 3'h1;
  localparam logic [2:0] DTC_M_PWM8 = 3'h2;
  localparam logic [2:0] DTC_M_CASC = 3'h3;
  localparam logic [2:0] DTC_M_TIMER16 = 3'h4;
  localparam logic [2:0] DTC_M_WARMUP = 3'h5;
  localparam logic [2:0] DTC_M_PWM16 = 3'h6;
  // Clock select codes
  localparam logic [2:0] DTC_CK_SLOWDIV = 3'h0;
  localparam logic [2:0] DTC_CK_DIV7 = 3'h1;
  localparam logic [2:0] DTC_CK_DIV5 = 3'h2;
  localparam logic [2:0] DTC_CK_DIV3 = 3'h3;
  localparam logic [2:0] DTC_CK_FS = 3'h4;
  localparam logic [2:0] DTC_CK_DIV1 = 3'h5;
  localparam logic [2:0] DTC_CK_FC = 3'h6;
  localparam logic [2:0] DTC_CK_PIN = 3'h7;
  // Divider tap positions
  localparam int DTC_TAP_11 = 10;
  localparam int DTC_TAP_7 = 6;
  localparam int DTC_TAP_5 = 4;
  localparam int DTC_TAP_3 = 2;
  localparam int DTC_TAP_1 = 0;
  localparam int DTC_FS_TAP_3 = 2;
  // Control register fields as one packed word
  typedef struct packed {
    logic ff;
    logic [2:0] clk_sel;
    logic run;
    logic [2:0] mode;
  } dtc_ctrl_t;
endpackage

// ===== dtc_properties.sv
// Bus handshake and counter control checks for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dtc_properties
  import dtc_pkg::*;
#(
  parameter int CNT_W = 8 // Counter width per unit
) (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_b_i, // Reset, active low
  input wire logic clk_en_i, // State enable
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Bus address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic timer_a_out_o, // Unit A flop
  input wire logic [CNT_W-1:0] count_a_o, // Unit A counter
  input wire logic [CNT_W-1:0] count_b_o // Unit B counter
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic tkn;
  logic wacc;
  logic stop_a;
  logic stop_b;
  // Accepted request, and stop writes landing at the ack edge
  assign tkn = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i;
  assign wacc = wb_cyc_i && wb_stb_i && wb_ack_o && clk_en_i && wb_we_i
    && wb_sel_i[0] && !wb_dat_i[DTC_RUN_BIT];
  // Stop writes to each control register, to A only with a mode code other than cascade
  assign stop_a = wacc && wb_adr_i == DTC_A_CTRL_OFF
    && wb_dat_i[2:0] != DTC_M_CASC;
  assign stop_b = wacc && wb_adr_i == DTC_B_CTRL_OFF;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_time_a: assert property (tkn |=> wb_ack_o)
    else $error("ack missing after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(tkn))
    else $error("ack without request");
  rd_upper_a: assert property (wb_ack_o && !wb_we_i |->
    wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  stop_clr_a: assert property (stop_a |-> ##2 count_a_o == '0
    && timer_a_out_o == $past(wb_dat_i[DTC_FF_BIT], 2))
    else $error("unit A stop did not clear or load flop");
  stop_clr_b_a: assert property (stop_b |-> ##2 count_b_o == '0)
    else $error("unit B stop did not clear counter");
  freeze_a: assert property (!clk_en_i |=>
    $stable(count_a_o) && $stable(count_b_o))
    else $error("counter moved while frozen");
  step_a: assert property ($changed(count_a_o) |->
    count_a_o == $past(count_a_o) + 1'h1 || count_a_o == '0)
    else $error("unit A counter jumped");
  casc_src_a: assert property ($changed(count_b_o) && count_b_o != '0
    |-> $past(count_a_o) == '1)
    else $error("unit B counted without A overflow");
  cover property (stop_a);
  cover property (count_b_o != '0);
  cover property (tkn && !wb_we_i);
endmodule
bind dtc_top dtc_properties #(.CNT_W(CNT_W)) dtc_properties_inst (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_a_out_o(timer_a_out_o),
  .count_a_o(count_a_o), .count_b_o(count_b_o));
`default_nettype wire

// ===== dtc_tick_sel.sv
// Source tick selector for one timer unit
`timescale 1ns/1ps
`default_nettype none
module dtc_tick_sel
  import dtc_pkg::*;
(
  input wire logic [2:0] sel_i, // Clock select code
  input wire logic slow_i, // Low-speed divider option or low-speed mode
  input wire logic [10:0] fc_edge_i, // One-cycle ticks of fc dividers
  input wire logic [2:0] fs_edge_i, // One-cycle ticks of fs dividers
  input wire logic fc_tick_i, // Raw fc tick
  input wire logic fs_tick_i, // Raw fs tick
  input wire logic pin_tick_i, // External pin edge
  output logic tick_o // Selected tick
);
  // Multiplex the source by code
  always_comb begin
    case (sel_i)
      DTC_CK_SLOWDIV: tick_o = slow_i ? fs_edge_i[DTC_FS_TAP_3]
                                      : fc_edge_i[DTC_TAP_11]; // R4
      DTC_CK_DIV7: tick_o = fc_edge_i[DTC_TAP_7]; // R4
      DTC_CK_DIV5: tick_o = fc_edge_i[DTC_TAP_5]; // R4
      DTC_CK_DIV3: tick_o = fc_edge_i[DTC_TAP_3]; // R4
      DTC_CK_FS: tick_o = fs_tick_i; // R4
      DTC_CK_DIV1: tick_o = fc_edge_i[DTC_TAP_1]; // R4
      DTC_CK_FC: tick_o = fc_tick_i; // R4
      default: tick_o = pin_tick_i; // R4
    endcase
  end
endmodule
`default_nettype wire

// ===== dtc_top.sv
// Dual 8-bit timer control block with Wishbone slave
// Summary of operation
// R1 - Unit A: control, period, width registers
// R2 - No period write while A runs; the code writes period_a_r at any time
// R3 - A width writable running only PWM; the code writes width_a_r in any mode
// R4 - A clock select picks eight sources
// R5 - A mode codes 000 to 011; the code stores any 3-bit code
// R6 - No A mode/clock/flipflop change running; the code writes ctrl_a_r at any time
// R7 - Start may set fields; stop keeps
// R8 - Cascade: A mode 011, B picks
// R9 - Cascade: A clock, B start, flipflop
// R10 - fc in low speed only warm-up; the code selects fc in any mode
// R11 - Unit B: control, period, width registers
// R12 - No period write while B runs; the code writes period_b_r at any time
// R13 - B width writable running only PWM; the code writes width_b_r in any mode
// R14 - Run 0 stops, clears; 1 starts
// R15 - Flipflop bit sets output initial level
// R16 - B adds 16-bit, warm-up, PWM16 modes
// R17 - B upper byte counts A overflow
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dtc_top
  import dtc_pkg::*;
#(
  parameter int CNT_W = 8 // Counter width per unit
) (
  input wire logic sys_clk_i, // 10 MHz system clock
  input wire logic rst_b_i, // Asynchronous reset, active low
  input wire logic clk_en_i, // Freezes all state when low
  input wire logic fc_tick_i, // High-frequency clock tick
  input wire logic fs_tick_i, // Low-frequency clock tick
  input wire logic slow_mode_i, // Low-speed run or sleep active
  input wire logic ext_pin_i, // External count pin level
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic timer_a_out_o, // Unit A output flip-flop
  output logic timer_b_out_o, // Unit B output flip-flop
  output logic [CNT_W-1:0] count_a_o, // Unit A counter
  output logic [CNT_W-1:0] count_b_o // Unit B counter
);
  dtc_ctrl_t ctrl_a_r;
  dtc_ctrl_t ctrl_b_r;
  logic [CNT_W-1:0] period_a_r;
  logic [CNT_W-1:0] width_a_r;
  logic [CNT_W-1:0] period_b_r;
  logic [CNT_W-1:0] width_b_r;
  logic div_opt_r;
  logic [10:0] fc_div_r;
  logic [2:0] fs_div_r;
  logic [10:0] fc_edge;
  logic [2:0] fs_edge;
  logic pin_prev_r;
  logic pin_tick;
  logic tick_a;
  logic ovf_a;
  logic casc;
  logic run_a;
  logic run_b;
  logic tick_b;
  logic b_run_d_r;
  logic a_run_d_r;
  logic wr;
  logic [31:0] rd_nxt;

  // Write lands at the edge where ack is high, low byte lane only
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign casc = (ctrl_a_r.mode == DTC_M_CASC); // R8
  assign run_a = casc ? ctrl_b_r.run : ctrl_a_r.run; // R9
  assign run_b = ctrl_b_r.run;
  assign pin_tick = ext_pin_i && !pin_prev_r;

  // Divider chain edge detection per tap
  genvar g;
  generate
    for (g = 0; g < 11; g++) begin : g_fc
      if (g == 0) begin : g_first
        assign fc_edge[g] = fc_tick_i && fc_div_r[0];
      end else begin : g_rest
        assign fc_edge[g] = fc_edge[g-1] && fc_div_r[g];
      end
    end
    for (g = 0; g < 3; g++) begin : g_fs
      if (g == 0) begin : g_first
        assign fs_edge[g] = fs_tick_i && fs_div_r[0];
      end else begin : g_rest
        assign fs_edge[g] = fs_edge[g-1] && fs_div_r[g];
      end
    end
  endgenerate

  // Prescaler counters and pin edge history
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fc_div_r <= 11'h000;
      fs_div_r <= 3'h0;
      pin_prev_r <= 1'b0;
    end else if (clk_en_i) begin
      if (fc_tick_i) fc_div_r <= fc_div_r + 11'h001;
      if (fs_tick_i) fs_div_r <= fs_div_r + 3'h1;
      pin_prev_r <= ext_pin_i;
    end
  end

  // Source select for unit A
  dtc_tick_sel u_sel_a (
    .sel_i(ctrl_a_r.clk_sel),
    .slow_i(div_opt_r || slow_mode_i),
    .fc_edge_i(fc_edge),
    .fs_edge_i(fs_edge),
    .fc_tick_i(fc_tick_i),
    .fs_tick_i(fs_tick_i),
    .pin_tick_i(pin_tick),
    .tick_o(tick_a)
  );

  // Unit B counts A overflow in 16-bit modes
  assign ovf_a = tick_a && (count_a_o == {CNT_W{1'b1}});
  assign tick_b = ctrl_b_r.mode[2] ? ovf_a : 1'b0; // R17

  // Register writes from the bus
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_a_r <= DTC_CTRL_RST; // R1
      ctrl_b_r <= DTC_CTRL_RST; // R11
      period_a_r <= CNT_W'(DTC_REG_RST);
      width_a_r <= CNT_W'(DTC_REG_RST);
      period_b_r <= CNT_W'(DTC_REG_RST);
      width_b_r <= CNT_W'(DTC_REG_RST);
      div_opt_r <= 1'b0;
    end else if (clk_en_i && wr) begin
      case (wb_adr_i)
        DTC_A_CTRL_OFF: ctrl_a_r <= wb_dat_i[7:0]; // R5
        DTC_B_CTRL_OFF: ctrl_b_r <= wb_dat_i[7:0]; // R16
        DTC_A_PERIOD_OFF: period_a_r <= wb_dat_i[CNT_W-1:0]; // R1
        DTC_A_WIDTH_OFF: width_a_r <= wb_dat_i[CNT_W-1:0]; // R1
        DTC_B_PERIOD_OFF: period_b_r <= wb_dat_i[CNT_W-1:0]; // R11
        DTC_B_WIDTH_OFF: width_b_r <= wb_dat_i[CNT_W-1:0]; // R11
        DTC_OPT_OFF: div_opt_r <= wb_dat_i[0];
        default: ;
      endcase
    end
  end

  // Delayed run flags read back in the status register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_run_d_r <= 1'b0;
      b_run_d_r <= 1'b0;
    end else if (clk_en_i) begin
      a_run_d_r <= run_a;
      b_run_d_r <= run_b;
    end
  end

  // Unit A counter: clear when stopped, count when running
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_a_o <= '0;
    end else if (clk_en_i) begin
      if (!run_a) count_a_o <= '0; // R14
      else if (tick_a) count_a_o <= count_a_o + 1'b1; // R14
    end
  end

  // Unit B counter: no tick in 8-bit modes, A overflow in 16-bit
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_b_o <= '0;
    end else if (clk_en_i) begin
      if (!run_b) count_b_o <= '0; // R14
      else if (tick_b) count_b_o <= count_b_o + 1'b1; // R17
    end
  end

  // Output flip-flops take the control level while stopped
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_a_out_o <= 1'b0;
      timer_b_out_o <= 1'b0;
    end else if (clk_en_i) begin
      if (!run_a) timer_a_out_o <= casc ? ctrl_b_r.ff : ctrl_a_r.ff; // R15 R9
      if (!run_b) timer_b_out_o <= ctrl_b_r.ff; // R15
    end
  end

  // Read data mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      DTC_A_CTRL_OFF: rd_nxt[7:0] = ctrl_a_r;
      DTC_B_CTRL_OFF: rd_nxt[7:0] = ctrl_b_r;
      DTC_A_PERIOD_OFF: rd_nxt[CNT_W-1:0] = period_a_r;
      DTC_A_WIDTH_OFF: rd_nxt[CNT_W-1:0] = width_a_r;
      DTC_B_PERIOD_OFF: rd_nxt[CNT_W-1:0] = period_b_r;
      DTC_B_WIDTH_OFF: rd_nxt[CNT_W-1:0] = width_b_r;
      DTC_STATUS_OFF: rd_nxt[3:0] = {timer_b_out_o, timer_a_out_o,
                                     b_run_d_r, a_run_d_r};
      DTC_OPT_OFF: rd_nxt[0] = div_opt_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Bus answer: ack one cycle after request, dropped next cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== tb_dtc_top.sv
// Self-checking bench for the dual timer control block
`timescale 1ns/1ps
`default_nettype none
module tb_dtc_top;
  import dtc_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic en = 1'h1;
  logic slow = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [2:0] tk = 3'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack, out_a, out_b;
  logic [7:0] cnt_a, cnt_b;
  logic [31:0] q[$];
  logic [7:0] offs[6] = '{DTC_A_CTRL_OFF, DTC_B_CTRL_OFF, DTC_A_PERIOD_OFF,
    DTC_A_WIDTH_OFF, DTC_B_PERIOD_OFF, DTC_B_WIDTH_OFF};
  logic [2:0] codes[3] = '{DTC_CK_FC, DTC_CK_FS, DTC_CK_PIN};
  logic [2:0] msk[3] = '{3'h1, 3'h2, 3'h4};
  logic [2:0] dcode[4] = '{DTC_CK_DIV3, DTC_CK_SLOWDIV, DTC_CK_SLOWDIV,
    DTC_CK_SLOWDIV};
  logic [2:0] dmsk[4] = '{3'h1, 3'h2, 3'h2, 3'h1};
  int mismatches = 0;
  int compares = 0;
  int seed = 32232;
  int n;
  dtc_top dtc_top_inst (.sys_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en),
    .fc_tick_i(tk[0]), .fs_tick_i(tk[1]), .slow_mode_i(slow),
    .ext_pin_i(tk[2]), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_a_out_o(out_a), .timer_b_out_o(out_b),
    .count_a_o(cnt_a), .count_b_o(cnt_b));
  task automatic check(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'h1 && i < 20);
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (i >= 20) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    wb(a, 1'h0, 8'h00);
  endtask
  // Tick pulses on the chosen sources, one cycle high then three low
  task automatic pulse(input logic [2:0] m, input int k);
    repeat (k) begin
      @(posedge clk);
      tk <= m;
      @(posedge clk);
      tk <= 3'h0;
      repeat (2) @(posedge clk);
    end
  endtask
  // Read data checked against the oldest noted value
  always @(posedge clk) begin
    if (ack === 1'h1 && we === 1'h0)
      check("rdata", rdat, q.pop_front());
  end
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    foreach (offs[j]) rd(offs[j], 8'h00);
    foreach (offs[j]) begin
      n = $random(seed) & 32'hF5;
      wb(offs[j], 1'h1, n[7:0]);
      rd(offs[j], n[7:0]);
    end
    rd(8'h3C, 8'h00);
    wb(DTC_B_CTRL_OFF, 1'h1, 8'h00);
    // The fc, fs and pin sources, then ticks on the unselected ones
    for (int c = 0; c < 3; c++) begin
      n = 1 + ($random(seed) & 15);
      wb(DTC_A_CTRL_OFF, 1'h1, {c[0], codes[c], 1'h0, DTC_M_TIMER8});
      wb(DTC_A_CTRL_OFF, 1'h1, {c[0], codes[c], 1'h1, DTC_M_TIMER8});
      pulse(msk[c], n);
      pulse(~msk[c], 3);
      repeat (3) @(posedge clk);
      check("cnt_a", cnt_a, n[7:0]);
      wb(DTC_A_CTRL_OFF, 1'h1, {c[0], codes[c], 1'h0, DTC_M_TIMER8});
      repeat (2) @(posedge clk);
      check("cnt_a stop", cnt_a, 8'h00);
      check("out_a", out_a, {31'h0, c[0]});
    end
    // Divided taps: 8k ticks on tap 3 and the fs tap, 2048k on fc tap 11, give k divided ticks
    for (int c = 0; c < 4; c++) begin
      n = (c == 3) ? 1 : 1 + ($random(seed) & 3);
      wb(DTC_OPT_OFF, 1'h1, {7'h00, c == 1});
      rd(DTC_OPT_OFF, {7'h00, c == 1});
      slow <= (c == 2);
      wb(DTC_A_CTRL_OFF, 1'h1, {1'h0, dcode[c], 1'h0, DTC_M_TIMER8});
      wb(DTC_A_CTRL_OFF, 1'h1, {1'h0, dcode[c], 1'h1, DTC_M_TIMER8});
      pulse(dmsk[c], (c == 3 ? 2048 : 8) * n);
      repeat (3) @(posedge clk);
      check("cnt_a div", cnt_a, n[7:0]);
      wb(DTC_A_CTRL_OFF, 1'h1, {1'h0, dcode[c], 1'h0, DTC_M_TIMER8});
    end
    // Cascade: A supplies clock, B starts and counts A overflow
    wb(DTC_A_CTRL_OFF, 1'h1, {1'h0, DTC_CK_FC, 1'h0, DTC_M_CASC});
    wb(DTC_B_CTRL_OFF, 1'h1, {1'h1, 3'h0, 1'h1, DTC_M_TIMER16});
    en <= 1'h0;
    repeat (3) @(posedge clk);
    en <= 1'h1;
    pulse(3'h1, 259);
    repeat (3) @(posedge clk);
    check("cnt_a casc", cnt_a, 8'h03);
    check("cnt_b casc", cnt_b, 8'h01);
    rd(DTC_STATUS_OFF, 8'h03);
    wb(DTC_B_CTRL_OFF, 1'h1, {1'h1, 3'h0, 1'h0, DTC_M_TIMER16});
    repeat (2) @(posedge clk);
    check("cnt_a casc stop", cnt_a, 8'h00);
    check("out_b", out_b, 32'h1);
    check("cnt_b casc stop", cnt_b, 8'h00);
    check("out_a casc", out_a, 32'h1);
    wrap_up();
  end
endmodule
`default_nettype wire
